// >>> dv/pmc_mem_mgr.sv
// Memory manager model that aborts vector-area and out-of-range accesses.
// Assumes access and address come from the core side on clk_sys.
`timescale 1ns/1ps
module pmc_mem_mgr (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic access,
    input wire logic [31:0] addr,
    input wire logic protect,
    input wire logic slow,
    output logic abort
);
    // ------------------------------------------------------------
    // Abort generation
    // ------------------------------------------------------------
    // The slow answer is one cycle later, as a manager with a table walk would give.
    logic [1:0] pend_q;
    wire bad = access && protect && (addr < 32'h00000020 || addr > 32'h03FFFFFF);
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pend_q <= 2'h0;
        end else begin
            pend_q <= {pend_q[0], bad};
        end
    end
    assign abort = slow ? pend_q[1] : pend_q[0];
endmodule : pmc_mem_mgr

// >>> dv/pmc_mode_sva.sv
// Concurrent checks on the mode and status word block.
// Assumes it is bound to the top module and watches its ports only.
`timescale 1ns/1ps
module pmc_mode_sva (
    input logic clk_sys,
    input logic rstn,
    input logic instr_valid,
    input logic [31:0] instr,
    input logic [31:0] instr_pc,
    input logic exc_req,
    input pmc_pkg::pmc_exc_t exc_kind,
    input logic [31:0] exc_return_addr,
    input logic mem_abort,
    input logic [31:0] current_status_word,
    input logic [31:0] saved_status_word,
    input logic [31:0] link_register,
    input logic link_we,
    input logic [2:0] active_bank,
    input logic legacy_mode,
    input logic [31:0] legacy_pc_status,
    input logic status_xfer_done,
    input logic branch_taken,
    input logic address_exception,
    input logic [31:0] exec_cycles
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    wire any_exc = exc_req || mem_abort;
    wire is_xfer = instr[27:26] == 2'h0 && !instr[20] && instr[24:23] == 2'h2;
    wire is_brl = instr[31:24] == 8'hEB;
    wire [4:0] mode = current_status_word[4:0];
    // A second event right after entry would rewrite the saved word, so the check waits for a quiet cycle.
    sequence s_entry;
        any_exc ##1 !any_exc && !instr_valid;
    endsequence
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_no_addr_exc; address_exception == 1'b0; endproperty
    a_no_addr_exc: assert property (p_no_addr_exc) else $error("address exception raised");
    property p_cycles; !any_exc |=> exec_cycles == $past(exec_cycles) + 32'($past(instr_valid)); endproperty
    a_cycles: assert property (p_cycles) else $error("cycle count step wrong");
    property p_exc_link;
        any_exc |=> link_we && link_register == $past(exc_return_addr) && current_status_word[pmc_pkg::BIT_I];
    endproperty
    a_exc_link: assert property (p_exc_link) else $error("exception link or mask wrong");
    property p_saved; s_entry |=> saved_status_word == $past(current_status_word, 2); endproperty
    a_saved: assert property (p_saved) else $error("saved word not the old status");
    // The bank and legacy outputs are decoded from the registered word, so they trail it by a cycle.
    property p_abort;
        mem_abort |=> (mode == pmc_pkg::MODE_ABT32) ##1 (active_bank == pmc_pkg::BANK_ABT);
    endproperty
    a_abort: assert property (p_abort) else $error("abort entry wrong");
    property p_fiq;
        exc_req && !mem_abort && exc_kind == pmc_pkg::EXC_FIQ |=>
            (mode == pmc_pkg::MODE_FIQ32 && current_status_word[pmc_pkg::BIT_F]) ##1
            (active_bank == pmc_pkg::BANK_FIQ);
    endproperty
    a_fiq: assert property (p_fiq) else $error("fast interrupt entry wrong");
    property p_legacy_bank;
        $past(mode[4]) == 1'b0 |-> legacy_mode && active_bank == {1'b0, $past(mode[1:0])};
    endproperty
    a_legacy_bank: assert property (p_legacy_bank) else $error("legacy bank wrong");
    property p_view;
        legacy_mode && $stable(current_status_word) |-> legacy_pc_status[1:0] == mode[1:0] &&
            legacy_pc_status[31:26] == {current_status_word[31:28], current_status_word[7:6]};
    endproperty
    a_view: assert property (p_view) else $error("combined view wrong");
    property p_brl;
        instr_valid && is_brl && !any_exc |=> branch_taken && link_we && link_register == $past(instr_pc) + 32'h4;
    endproperty
    a_brl: assert property (p_brl) else $error("branch link wrong");
    property p_xfer; instr_valid && is_xfer && !any_exc |=> status_xfer_done; endproperty
    a_xfer: assert property (p_xfer) else $error("status transfer not done");
endmodule : pmc_mode_sva

// >>> dv/processor_mode_compat_test.sv
// Self-checking testbench for the mode and status word block.
// Assumes the core and the memory manager model share clk_sys and rstn.
`timescale 1ns/1ps
module processor_mode_compat_test;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic clk_sys, rstn, instr_valid, exc_req, protect, slow;
    logic [31:0] instr, instr_pc, xfer_operand, exc_return_addr;
    pmc_pkg::pmc_exc_t exc_kind;
    logic mem_abort, link_we, legacy, done, taken, addr_exc;
    logic [31:0] status, saved, link, view, mfs, target, cycles;
    logic [2:0] bank;
    int errors, comparisons;
    pmc_mode_core uut (.clk_sys(clk_sys), .rstn(rstn), .instr_valid(instr_valid), .instr(instr),
        .instr_pc(instr_pc), .xfer_operand(xfer_operand), .exc_req(exc_req), .exc_kind(exc_kind),
        .exc_return_addr(exc_return_addr), .mem_abort(mem_abort), .current_status_word(status),
        .saved_status_word(saved), .link_register(link), .link_we(link_we), .active_bank(bank),
        .legacy_mode(legacy), .legacy_pc_status(view), .move_from_status(mfs), .status_xfer_done(done),
        .branch_target(target), .branch_taken(taken), .address_exception(addr_exc), .exec_cycles(cycles));
    pmc_mem_mgr mm (.clk_sys(clk_sys), .rstn(rstn), .access(instr_valid), .addr(instr_pc),
        .protect(protect), .slow(slow), .abort(mem_abort));
    // ------------------------------------------------------------
    // Drivers and compare
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    // Each request waits one edge first, so valid is never lowered and raised in one time step.
    task automatic issue(input logic [31:0] op, input logic [31:0] pc, input logic [31:0] opnd);
        @(negedge clk_sys);
        instr = op;
        instr_pc = pc;
        xfer_operand = opnd;
        instr_valid = 1'b1;
        @(negedge clk_sys);
        instr_valid = 1'b0;
    endtask : issue
    task automatic wstat(input logic [31:0] v);
        issue(32'hE129F000, 32'h00000100, v);
    endtask : wstat
    task automatic take_exc(input pmc_pkg::pmc_exc_t k, input logic [31:0] ra);
        @(negedge clk_sys);
        exc_kind = k;
        exc_return_addr = ra;
        exc_req = 1'b1;
        @(negedge clk_sys);
        exc_req = 1'b0;
    endtask : take_exc
    task automatic give_verdict();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_exc();
        logic [4:0] em [4];
        logic [31:0] s;
        pmc_pkg::pmc_exc_t k;
        em = '{pmc_pkg::MODE_UND32, pmc_pkg::MODE_ABT32, pmc_pkg::MODE_IRQ32, pmc_pkg::MODE_FIQ32};
        for (int i = 0; i < 4; i++) begin
            k = pmc_pkg::pmc_exc_t'(i);
            s = {4'h9, 20'h0, 3'h0, (i % 2 == 0) ? pmc_pkg::MODE_SVC32 : pmc_pkg::MODE_LIRQ};
            wstat(s);
            take_exc(k, 32'h00000400 + i);
            check("link", 32'h00000400 + i, link);
            check("status", {4'h9, 20'h0, 1'b1, k == pmc_pkg::EXC_FIQ, 1'b0, em[i]}, status);
            @(negedge clk_sys);
            check("saved", s, saved);
        end
    endtask : t_exc
    task automatic t_branch();
        logic [31:0] c0, c1;
        wstat(32'hF0000013);
        c0 = cycles;
        issue(32'hEB7FFFFF, 32'h00001000, 32'h0);
        check("link", 32'h00001004, link);
        check("taken", 32'h1, {31'h0, taken});
        check("target", 32'h02001004, target);
        issue(32'hEB800000, 32'h03000000, 32'h0);
        check("target", 32'h01000008, target);
        c1 = cycles;
        wstat(32'h90000082);
        issue(32'hEB000004, 32'h03FFFFF0, 32'h0);
        check("target", 32'h00000008, target);
        check("view", 32'h98000002, view & 32'hFC000003);
        issue(32'hEBFFFFFF, 32'h00000100, 32'h0);
        check("target", 32'h00000104, target);
        check("cycles", c1 - c0, cycles - c1 - 32'h1);
    endtask : t_branch
    task automatic t_abort();
        int n;
        wstat(32'h60000013);
        issue(32'hE10F0000, 32'h00000010, 32'h0);
        repeat (2) @(negedge clk_sys);
        check("status", 32'h60000013, status);
        protect = 1'b1;
        for (int s = 0; s < 2; s++) begin
            slow = s[0];
            wstat(32'h60000013);
            issue(32'hE10F0000, s ? 32'h04000000 : 32'h00000010, 32'h0);
            check("read", 32'h60000013, mfs);
            n = 0;
            while (status[4:0] !== pmc_pkg::MODE_ABT32 && n < 4) begin
                @(negedge clk_sys);
                n++;
            end
            if (n == 4) begin
                check("abort mode", 32'h17, {27'h0, status[4:0]});
                give_verdict();
            end
            check("status", 32'h60000097, status);
            check("addr exc", 32'h0, {31'h0, addr_exc});
            @(negedge clk_sys);
            check("bank", {29'h0, pmc_pkg::BANK_ABT}, {29'h0, bank});
            check("saved", 32'h60000013, saved);
        end
        issue(32'hE169F000, 32'h00000100, 32'hA00000D1);
        issue(32'hE14F0000, 32'h00000100, 32'h0);
        check("done", 32'h1, {31'h0, done});
        check("read saved", 32'hA00000D1, mfs);
    endtask : t_abort
    task automatic t_modes();
        logic [4:0] md [8];
        logic [2:0] bk [8];
        logic [31:0] v;
        md = '{pmc_pkg::MODE_LFIQ, pmc_pkg::MODE_LIRQ, pmc_pkg::MODE_LSVC, pmc_pkg::MODE_FIQ32,
            pmc_pkg::MODE_IRQ32, pmc_pkg::MODE_ABT32, pmc_pkg::MODE_UND32, pmc_pkg::MODE_USR32};
        bk = '{pmc_pkg::BANK_FIQ, pmc_pkg::BANK_IRQ, pmc_pkg::BANK_SVC, pmc_pkg::BANK_FIQ,
            pmc_pkg::BANK_IRQ, pmc_pkg::BANK_ABT, pmc_pkg::BANK_UND, pmc_pkg::BANK_USR};
        for (int i = 0; i < 8; i++) begin
            v = {4'h5, 20'h0, 3'h6, md[i]};
            wstat(v);
            check("status", v, status);
            @(negedge clk_sys);
            check("bank", {29'h0, bk[i]}, {29'h0, bank});
            check("legacy", {31'h0, ~md[i][4]}, {31'h0, legacy});
        end
        wstat(32'hA00000D3);
        check("user write", 32'hA00000D0, status);
        take_exc(pmc_pkg::EXC_IRQ, 32'h0);
        issue(32'hE329F4F1, 32'h00000100, 32'h0);
        check("legacy user", 32'hF0000000, status);
        @(negedge clk_sys);
        check("legacy", 32'h1, {31'h0, legacy});
        check("bank", 32'h0, {29'h0, bank});
    endtask : t_modes
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        {rstn, instr_valid, exc_req, protect, slow} = 5'h00;
        {instr, instr_pc, xfer_operand, exc_return_addr} = 128'h0;
        exc_kind = pmc_pkg::EXC_UND;
        errors = 0;
        comparisons = 0;
        repeat (2) @(negedge clk_sys);
        rstn = 1'b1;
        check("status", pmc_pkg::STATUS_RESET, status);
        check("bank", {29'h0, pmc_pkg::BANK_SVC}, {29'h0, bank});
        check("legacy", 32'h0, {31'h0, legacy});
        t_exc();
        t_branch();
        t_abort();
        t_modes();
        give_verdict();
    end
endmodule : processor_mode_compat_test
bind pmc_mode_core pmc_mode_sva chk (.clk_sys(clk_sys), .rstn(rstn), .instr_valid(instr_valid), .instr(instr),
    .instr_pc(instr_pc), .exc_req(exc_req), .exc_kind(exc_kind), .exc_return_addr(exc_return_addr),
    .mem_abort(mem_abort), .current_status_word(current_status_word), .saved_status_word(saved_status_word),
    .link_register(link_register), .link_we(link_we), .active_bank(active_bank), .legacy_mode(legacy_mode),
    .legacy_pc_status(legacy_pc_status), .status_xfer_done(status_xfer_done), .branch_taken(branch_taken),
    .address_exception(address_exception), .exec_cycles(exec_cycles));

// >>> hdl/pmc_bank_sel.sv
// Mode decoder: maps a mode field to its register bank and legacy flag.
// Assumes the mode field comes from the status register or from exception or write decode on the same clock.
`timescale 1ns/1ps
module pmc_bank_sel (
    pmc_mode_if.dec mi
);
    // ---------------------------------------------------------------
    // Decoding
    // ---------------------------------------------------------------
    // Both forms of a mode share one bank, but the case still decodes all five mode bits.
    function automatic logic [2:0] bank_of(input logic [4:0] m);
        logic [2:0] b;
        b = pmc_pkg::BANK_USR;
        case (m)
            pmc_pkg::MODE_LFIQ, pmc_pkg::MODE_FIQ32: b = pmc_pkg::BANK_FIQ;
            pmc_pkg::MODE_LIRQ, pmc_pkg::MODE_IRQ32: b = pmc_pkg::BANK_IRQ;
            pmc_pkg::MODE_LSVC, pmc_pkg::MODE_SVC32: b = pmc_pkg::BANK_SVC;
            pmc_pkg::MODE_ABT32: b = pmc_pkg::BANK_ABT;
            pmc_pkg::MODE_UND32: b = pmc_pkg::BANK_UND;
            default: b = pmc_pkg::BANK_USR;
        endcase
        return b;
    endfunction : bank_of

    wire [2:0] bank_w = bank_of(mi.mode);
    wire legacy_w = (mi.mode[4:pmc_pkg::LEGACY_MODE_W] == 3'h0);
    wire valid_w = legacy_w || (mi.mode == pmc_pkg::MODE_USR32) || (bank_w != pmc_pkg::BANK_USR);

    assign mi.bank = bank_w;
    assign mi.legacy = legacy_w;
    assign mi.valid_mode = valid_w;
    assign mi.has_saved = (bank_w != pmc_pkg::BANK_USR);
endmodule : pmc_bank_sel

// >>> hdl/pmc_mode_core.sv
// Operating mode and status word logic giving 26-bit compatibility on a 32-bit core.
// Assumes the decode stage presents one instruction event per cycle on clk_sys and that
// an external memory manager raises aborts for range and vector protection.
`timescale 1ns/1ps

module pmc_mode_core (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic instr_valid,
    input wire logic [31:0] instr,
    input wire logic [31:0] instr_pc,
    input wire logic [31:0] xfer_operand,
    input wire logic exc_req,
    input wire pmc_pkg::pmc_exc_t exc_kind,
    input wire logic [31:0] exc_return_addr,
    input wire logic mem_abort,
    output logic [31:0] current_status_word,
    output logic [31:0] saved_status_word,
    output logic [31:0] link_register,
    output logic link_we,
    output logic [2:0] active_bank,
    output logic legacy_mode,
    output logic [31:0] legacy_pc_status,
    output logic [31:0] move_from_status,
    output logic status_xfer_done,
    output logic [31:0] branch_target,
    output logic branch_taken,
    output logic address_exception,
    output logic [31:0] exec_cycles
);
    // ---------------------------------------------------------------
    // Instruction decode
    // ---------------------------------------------------------------
    function automatic logic is_status_xfer(input logic [31:0] i);
        logic [3:0] op;
        op = i[24:21];
        return (i[27:26] == 2'h0) && !i[20] &&
               ((op == pmc_pkg::OP_AND) || (op == pmc_pkg::OP_XOR) ||
                (op == pmc_pkg::OP_SUB) || (op == pmc_pkg::OP_ADD));
    endfunction : is_status_xfer

    wire xfer_hit = instr_valid && is_status_xfer(instr);
    wire xfer_to = xfer_hit && instr[21];
    wire xfer_sav = instr[22];
    wire [31:0] xfer_imm = {24'h000000, instr[7:0]} >> {instr[11:8], 1'b0} |
                           {24'h000000, instr[7:0]} << (6'd32 - {1'b0, instr[11:8], 1'b0});
    wire [31:0] xfer_src = instr[25] ? xfer_imm : xfer_operand;
    wire is_branch = instr_valid && (instr[27:25] == 3'h5);
    wire is_link = is_branch && instr[24];
    wire [31:0] br_offset = {{6{instr[23]}}, instr[23:0], 2'b00};
    wire [31:0] br_target_w = instr_pc + 32'h00000008 + br_offset;

    // ---------------------------------------------------------------
    // Mode state
    // ---------------------------------------------------------------
    logic [31:0] status_q;
    logic [31:0] status_d;
    pmc_mode_if mi ();
    assign mi.mode = status_q[pmc_pkg::MODE_W-1:0];
    pmc_bank_sel u_bank (
        .mi(mi)
    );

    // Exception target mode is always a full-width one, even from a legacy mode.
    function automatic logic [4:0] exc_mode(input pmc_pkg::pmc_exc_t k);
        logic [4:0] m;
        m = pmc_pkg::MODE_SVC32;
        case (k)
            pmc_pkg::EXC_UND: m = pmc_pkg::MODE_UND32;
            pmc_pkg::EXC_ABT: m = pmc_pkg::MODE_ABT32;
            pmc_pkg::EXC_IRQ: m = pmc_pkg::MODE_IRQ32;
            pmc_pkg::EXC_FIQ: m = pmc_pkg::MODE_FIQ32;
            default: m = pmc_pkg::MODE_SVC32;
        endcase
        return m;
    endfunction : exc_mode

    pmc_mode_if ti ();
    assign ti.mode = exc_mode(exc_kind);
    pmc_bank_sel u_tbank (
        .mi(ti)
    );

    // A memory abort raised by the external manager enters abort mode like any exception.
    wire take_exc = exc_req || mem_abort;
    wire [4:0] tgt_mode = mem_abort ? pmc_pkg::MODE_ABT32 : ti.mode;
    wire [2:0] tgt_bank = mem_abort ? pmc_pkg::BANK_ABT : ti.bank;
    wire privileged = (mi.bank != pmc_pkg::BANK_USR) || (mi.mode != pmc_pkg::MODE_USR32 && !mi.legacy) ||
                      (mi.mode != pmc_pkg::MODE_LUSR && mi.legacy);
    wire [31:0] wmask = privileged ? pmc_pkg::STATUS_WMASK : pmc_pkg::USER_WMASK;
    wire [31:0] merged = (status_q & ~wmask) | (xfer_src & wmask);
    pmc_mode_if ni ();
    assign ni.mode = merged[pmc_pkg::MODE_W-1:0];
    pmc_bank_sel u_nbank (
        .mi(ni)
    );
    // Writes naming an unknown mode keep the old mode so the core never sits in a hole.
    wire [31:0] merged_ok = ni.valid_mode ? merged :
                            {merged[31:pmc_pkg::MODE_W], status_q[pmc_pkg::MODE_W-1:0]};
    wire cur_write = xfer_to && !xfer_sav && !take_exc;
    wire sav_write = xfer_to && xfer_sav && mi.has_saved && !take_exc;

    always_comb begin
        status_d = status_q;
        if (take_exc) begin
            status_d = {status_q[31:8], 1'b1, status_q[6:pmc_pkg::MODE_W], tgt_mode};
            status_d[pmc_pkg::BIT_F] = status_q[pmc_pkg::BIT_F] | (exc_kind == pmc_pkg::EXC_FIQ && !mem_abort);
        end else if (cur_write) begin
            status_d = merged_ok;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            status_q <= pmc_pkg::STATUS_RESET;
        end else begin
            status_q <= status_d;
        end
    end

    // ---------------------------------------------------------------
    // Saved status words
    // ---------------------------------------------------------------
    logic [31:0] saved_rd;
    wire sv_we = take_exc || sav_write;
    wire [2:0] sv_bank = take_exc ? tgt_bank : mi.bank;
    wire [31:0] sv_data = take_exc ? status_q : ((saved_rd & ~wmask) | (xfer_src & wmask));
    pmc_saved_words u_saved (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .wr_en(sv_we),
        .wr_bank(sv_bank),
        .wr_data(sv_data),
        .rd_bank(mi.bank),
        .rd_data(saved_rd)
    );

    // ---------------------------------------------------------------
    // Legacy combined view
    // ---------------------------------------------------------------
    // Old layout: flags on top, I and F in 27 and 26, mode in the two lowest bits.
    wire [31:0] legacy_view = {status_q[pmc_pkg::FLAG_N:pmc_pkg::FLAG_V], status_q[pmc_pkg::BIT_I],
                               status_q[pmc_pkg::BIT_F], 26'h0000000} |
                              (instr_pc & pmc_pkg::LEGACY_PC_MASK) |
                              {30'h00000000, status_q[pmc_pkg::LEGACY_MODE_W-1:0]};
    wire [31:0] mfs_val = xfer_sav ? saved_rd : status_q;

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    logic [31:0] link_q;
    logic link_we_q;
    logic [31:0] mfs_q;
    logic xfer_done_q;
    logic [31:0] brt_q;
    logic brk_q;
    logic [31:0] cyc_q;
    logic [31:0] leg_q;
    logic [31:0] saved_q;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            link_q <= 32'h00000000;
            link_we_q <= 1'b0;
        end else begin
            link_we_q <= take_exc || is_link;
            if (take_exc) begin
                link_q <= exc_return_addr;
            end else if (is_link) begin
                link_q <= instr_pc + 32'h00000004;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mfs_q <= 32'h00000000;
            xfer_done_q <= 1'b0;
            brt_q <= 32'h00000000;
            brk_q <= 1'b0;
        end else begin
            xfer_done_q <= xfer_hit && !take_exc;
            if (xfer_hit && !instr[21]) begin
                mfs_q <= mfs_val;
            end
            brk_q <= is_branch && !take_exc;
            brt_q <= mi.legacy ? (br_target_w & pmc_pkg::LEGACY_PC_MASK) : br_target_w;
        end
    end

    // Cycle accounting adds one cycle per valid instruction, never depending on the mode width.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cyc_q <= 32'h00000000;
            leg_q <= 32'h00000000;
            saved_q <= 32'h00000000;
        end else begin
            if (instr_valid) begin
                cyc_q <= cyc_q + 32'(pmc_pkg::STATUS_XFER_CYCLES);
            end
            leg_q <= legacy_view;
            saved_q <= saved_rd;
        end
    end

    logic [2:0] bank_q;
    logic legacy_q;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            bank_q <= pmc_pkg::BANK_SVC;
            legacy_q <= 1'b0;
        end else begin
            bank_q <= mi.bank;
            legacy_q <= mi.legacy;
        end
    end

    // No width straps exist; the core is always full width in both spaces.
    logic addr_exc_q;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            addr_exc_q <= 1'b0;
        end else begin
            addr_exc_q <= 1'b0;
        end
    end

    assign current_status_word = status_q;
    assign saved_status_word = saved_q;
    assign link_register = link_q;
    assign link_we = link_we_q;
    assign active_bank = bank_q;
    assign legacy_mode = legacy_q;
    assign legacy_pc_status = leg_q;
    assign move_from_status = mfs_q;
    assign status_xfer_done = xfer_done_q;
    assign branch_target = brt_q;
    assign branch_taken = brk_q;
    assign address_exception = addr_exc_q;
    assign exec_cycles = cyc_q;
endmodule : pmc_mode_core

// >>> hdl/pmc_mode_if.sv
// Interface carrying the current, exception target or written mode between the status logic and the bank selector.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface pmc_mode_if;
    logic [4:0] mode;
    logic [2:0] bank;
    logic legacy;
    logic valid_mode;
    logic has_saved;
    modport src (output mode, input bank, legacy, valid_mode, has_saved);
    modport dec (input mode, output bank, legacy, valid_mode, has_saved);
endinterface : pmc_mode_if

// >>> hdl/pmc_pkg.sv
// Package for the processor mode and status word block.
// Assumes a single core clock and an active-low asynchronous reset.
package pmc_pkg;
    // ---------------------------------------------------------------
    // Mode field encodings
    // ---------------------------------------------------------------
    localparam logic [4:0] MODE_LUSR = 5'h00;
    localparam logic [4:0] MODE_LFIQ = 5'h01;
    localparam logic [4:0] MODE_LIRQ = 5'h02;
    localparam logic [4:0] MODE_LSVC = 5'h03;
    localparam logic [4:0] MODE_USR32 = 5'h10;
    localparam logic [4:0] MODE_FIQ32 = 5'h11;
    localparam logic [4:0] MODE_IRQ32 = 5'h12;
    localparam logic [4:0] MODE_SVC32 = 5'h13;
    localparam logic [4:0] MODE_ABT32 = 5'h17;
    localparam logic [4:0] MODE_UND32 = 5'h1B;
    // ---------------------------------------------------------------
    // Status word layout and reset value
    // ---------------------------------------------------------------
    localparam int FLAG_N = 31;
    localparam int FLAG_Z = 30;
    localparam int FLAG_C = 29;
    localparam int FLAG_V = 28;
    localparam int BIT_I = 7;
    localparam int BIT_F = 6;
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 5;
    localparam int LEGACY_MODE_W = 2;
    localparam logic [31:0] STATUS_RESET = 32'h000000D3;
    localparam logic [31:0] STATUS_WMASK = 32'hF00000DF;
    localparam logic [31:0] USER_WMASK = 32'hF0000000;
    // ---------------------------------------------------------------
    // Banks, saved words and branch range
    // ---------------------------------------------------------------
    localparam int NUM_SAVED = 5;
    localparam int SAVED_IDX_W = 3;
    localparam int NUM_BANKS = 6;
    localparam logic [2:0] BANK_USR = 3'h0;
    localparam logic [2:0] BANK_FIQ = 3'h1;
    localparam logic [2:0] BANK_IRQ = 3'h2;
    localparam logic [2:0] BANK_SVC = 3'h3;
    localparam logic [2:0] BANK_ABT = 3'h4;
    localparam logic [2:0] BANK_UND = 3'h5;
    localparam int BRANCH_RANGE_MB = 32;
    localparam logic [31:0] BRANCH_RANGE_BYTES = 32'(BRANCH_RANGE_MB * 1024 * 1024);
    localparam logic [3:0] OP_AND = 4'h8;
    localparam logic [3:0] OP_XOR = 4'h9;
    localparam logic [3:0] OP_SUB = 4'hA;
    localparam logic [3:0] OP_ADD = 4'hB;
    localparam logic [31:0] LEGACY_PC_MASK = 32'h03FFFFFC;
    localparam int STATUS_XFER_CYCLES = 1;
    typedef enum logic [1:0] {EXC_UND, EXC_ABT, EXC_IRQ, EXC_FIQ} pmc_exc_t;
endpackage : pmc_pkg

// >>> hdl/pmc_saved_words.sv
// Saved status words, one per exception-entered mode.
// Assumes the index is never the user bank when a write is asked for.
`timescale 1ns/1ps
module pmc_saved_words (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic wr_en,
    input wire logic [2:0] wr_bank,
    input wire logic [31:0] wr_data,
    input wire logic [2:0] rd_bank,
    output logic [31:0] rd_data
);
    // ---------------------------------------------------------------
    // Storage
    // ---------------------------------------------------------------
    logic [31:0] saved_q [pmc_pkg::NUM_SAVED];

    genvar g;
    generate
        for (g = 0; g < pmc_pkg::NUM_SAVED; g++) begin : g_saved
            wire hit = wr_en && (wr_bank == 3'(g + 1));
            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    saved_q[g] <= pmc_pkg::STATUS_RESET;
                end else if (hit) begin
                    saved_q[g] <= wr_data;
                end
            end
        end
    endgenerate

    // Reading the user bank would wrap the index to 7, past the last stored word, so return zero.
    wire rd_ok = (rd_bank != pmc_pkg::BANK_USR) && (rd_bank <= 3'(pmc_pkg::NUM_SAVED));
    wire [2:0] rd_idx = rd_bank - 3'h1;
    assign rd_data = rd_ok ? saved_q[rd_idx] : 32'h00000000;
endmodule : pmc_saved_words
